// [hw/pdc_pkg.sv]
/*
 * Shared constants for the peripheral DMA channel block: register offsets
 * inside one channel window, field positions, reset values, size codes
 * and the engine state encoding.
 * Assumes a 32-bit register bus with byte addresses.
 */
package pdc_pkg;

   // channel window: channel m starts at m * 0x040
   localparam int unsigned CH_SHIFT = 6;
   localparam logic [31:0] CH_STRIDE = 32'h0000_0040;

   localparam logic [5:0] OFF_MEMORY_POINTER = 6'h00;
   localparam logic [5:0] OFF_PERIPHERAL_SELECT = 6'h04;
   localparam logic [5:0] OFF_ITEM_COUNTER = 6'h08;
   localparam logic [5:0] OFF_POINTER_RELOAD = 6'h0C;
   localparam logic [5:0] OFF_COUNTER_RELOAD = 6'h10;
   localparam logic [5:0] OFF_CHANNEL_CONTROL = 6'h14;
   localparam logic [5:0] OFF_CHANNEL_MODE = 6'h18;
   localparam logic [5:0] OFF_CHANNEL_STATUS = 6'h1C;
   localparam logic [5:0] OFF_INTERRUPT_ENABLE = 6'h20;
   localparam logic [5:0] OFF_INTERRUPT_DISABLE = 6'h24;
   localparam logic [5:0] OFF_INTERRUPT_MASK = 6'h28;
   localparam logic [5:0] OFF_INTERRUPT_STATUS = 6'h2C;

   localparam int unsigned CTRL_TEN_BIT = 0;
   localparam int unsigned CTRL_TRANSFER_DISABLE_BIT_BIT = 1;
   localparam int unsigned CTRL_ERROR_CLEAR_BIT_BIT = 8;
   localparam int unsigned STATUS_TEN_BIT = 0;
   localparam int unsigned IRQ_RCZ_BIT = 0;
   localparam int unsigned IRQ_TRC_BIT = 1;
   localparam int unsigned IRQ_TRANSFER_ERROR_FLAG_BIT = 2;
   localparam int unsigned IRQ_W = 3;
   localparam int unsigned CNT_W = 16;

   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;

   localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
   localparam logic [31:0] STEP_HALF = 32'h0000_0002;
   localparam logic [31:0] STEP_WORD = 32'h0000_0004;

   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [31:0] MASK_BYTE = 32'h0000_00FF;
   localparam logic [31:0] MASK_HALF = 32'h0000_FFFF;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PER_RD,
      ST_MEM_WR,
      ST_MEM_RD,
      ST_PER_WR
   } pdc_state_type;

endpackage

// [hw/pdc_dma_top.sv]
/*
 * Multi-channel peripheral DMA engine: per-channel register sets on an
 * Avalon-MM slave, fixed-priority channel arbiter, one item mover that
 * reads the selected peripheral holding register or memory and writes
 * the other side, with double-buffer reload.
 * Assumes peripheral requests, peripheral and memory ports are logic on
 * the same clock; done strobes are one-cycle pulses answering a held req.
 */
// Summary of operation
// R01 - peripheral selector code picks handshake line, direction and holding address
// R02 - per-channel item size byte, halfword or word from mode register
// R03 - memory pointer steps by one, two or four after each item
// R04 - item counter counts items, drops by one per completed item
// R05 - enabled channel starts as soon as counter or reload is non-zero
// R06 - counter zero with non-zero reload copies both reload registers in
// R07 - both reload registers clear right after a reload
// R08 - writing counter reload while counter is zero loads pointer and counter
// R09 - peripheral data kept bit for bit, bits above size forced to zero
// R10 - memory accesses use item size and natural lane alignment
// R11 - control enable and disable bits set and clear the status enable
// R12 - enabled channel serves requests while counters are not both zero
// R13 - interrupt enable and disable registers set and clear the readable mask
// R14 - sources: reload zero, transfer finished, transfer error
// R15 - lowest numbered requesting channel wins
// R16 - memory access error flags the channel and halts only that channel
// R17 - software rewrites pointer before writing error clear
// R18 - unmasked transfer error raises the channel interrupt at once
// R19 - channel m registers sit at m times 0x040
// R20 - pointer and counter readable at any time, showing progress
// R21 - peripheral requests, engine acknowledges when the item starts
// R22 - channel count is a parameter, channels fully independent
`timescale 1ns/1ps
module pdc_dma_top #(
   parameter int NCH = 4,
   parameter int PID_W = 5,
   parameter logic [31:0] HOLD_BASE = 32'h0000_0000,
   localparam int CHW = (NCH > 1) ? $clog2(NCH) : 1,
   localparam int ADDR_W = CHW + 6,
   localparam int NPER = 1 << PID_W
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [NPER-1:0] periph_req_i,
   output logic [NPER-1:0] periph_ack_o,
   output logic pb_req_o,
   output logic pb_we_o,
   output logic [31:0] pb_addr_o,
   output logic [31:0] pb_wdata_o,
   input wire logic [31:0] pb_rdata_i,
   input wire logic pb_done_i,
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [31:0] mem_addr_o,
   output logic [1:0] mem_size_o,
   output logic [31:0] mem_wdata_o,
   input wire logic [31:0] mem_rdata_i,
   input wire logic mem_done_i,
   input wire logic mem_err_i,
   output logic [NCH-1:0] irq_o
);

   typedef struct packed {
      logic [NCH-1:0][31:0] memory_pointer;
      logic [NCH-1:0][PID_W-1:0] peripheral_selector_code;
      logic [NCH-1:0][pdc_pkg::CNT_W-1:0] item_counter;
      logic [NCH-1:0][31:0] pointer_reload;
      logic [NCH-1:0][pdc_pkg::CNT_W-1:0] counter_reload;
      logic [NCH-1:0][1:0] size;
      logic [NCH-1:0] en;
      logic [NCH-1:0] err;
      logic [NCH-1:0][pdc_pkg::IRQ_W-1:0] interrupt_mask;
      pdc_pkg::pdc_state_type st;
      logic [CHW-1:0] ch;
      logic [31:0] data;
      logic ack;
      logic [31:0] rdata;
   } pdc_regs_type;

   pdc_regs_type state_q;
   pdc_regs_type state_d;

   function automatic logic [31:0] step_of(input logic [1:0] size);
      unique case (size)
         pdc_pkg::SIZE_BYTE: step_of = pdc_pkg::STEP_BYTE;
         pdc_pkg::SIZE_HALF: step_of = pdc_pkg::STEP_HALF;
         default: step_of = pdc_pkg::STEP_WORD;
      endcase
   endfunction

   function automatic logic [31:0] mask_item(input logic [1:0] size, input logic [31:0] d);
      unique case (size)
         pdc_pkg::SIZE_BYTE: mask_item = d & pdc_pkg::MASK_BYTE;
         pdc_pkg::SIZE_HALF: mask_item = d & pdc_pkg::MASK_HALF;
         default: mask_item = d;
      endcase
   endfunction

   // pick the item out of its byte lanes
   function automatic logic [31:0] lane_get(input logic [1:0] size, input logic [1:0] a,
                                            input logic [31:0] d);
      unique case (size)
         pdc_pkg::SIZE_BYTE: lane_get = mask_item(size, d >> {a, 3'h0});
         pdc_pkg::SIZE_HALF: lane_get = mask_item(size, d >> {a[1], 4'h0});
         default: lane_get = d;
      endcase
   endfunction

   // copy the item into every lane so any aligned address finds it
   function automatic logic [31:0] lane_put(input logic [1:0] size, input logic [31:0] d);
      unique case (size)
         pdc_pkg::SIZE_BYTE: lane_put = {4{d[7:0]}};
         pdc_pkg::SIZE_HALF: lane_put = {2{d[15:0]}};
         default: lane_put = d;
      endcase
   endfunction

   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
      be_merge = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            be_merge[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
   endfunction

   // memory to peripheral when the top selector bit is set
   function automatic logic pid_is_tx(input logic [PID_W-1:0] peripheral_selector_code);
      pid_is_tx = peripheral_selector_code[PID_W-1];
   endfunction

   function automatic logic [31:0] hold_addr(input logic [PID_W-1:0] peripheral_selector_code);
      hold_addr = HOLD_BASE + 32'({peripheral_selector_code, 2'h0});
   endfunction

   logic [CHW-1:0] bus_ch;
   logic [5:0] bus_off;
   logic bus_hit;
   logic bus_wr;
   logic [31:0] rd_word;
   logic [NCH-1:0] elig;
   logic [NCH-1:0] busy;
   logic [CHW-1:0] grant;
   logic item_fin;
   logic mem_fail;
   logic [NCH-1:0][pdc_pkg::IRQ_W-1:0] interrupt_status;

   // R19 channel window decode
   assign bus_ch = avs_address_i[ADDR_W-1:pdc_pkg::CH_SHIFT];
   assign bus_off = avs_address_i[5:0];
   assign bus_hit = 32'(bus_ch) < 32'(NCH);
   assign bus_wr = avs_write_i && state_q.ack && bus_hit;
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !state_q.ack;
   assign avs_readdata_o = state_q.rdata;

   // R14 raw source levels, error is sticky
   // R22 one independent set per channel
   generate
      for (genvar c = 0; c < NCH; c++) begin : g_ch
         assign interrupt_status[c][pdc_pkg::IRQ_RCZ_BIT] = state_q.counter_reload[c] == '0;
         assign interrupt_status[c][pdc_pkg::IRQ_TRC_BIT] = state_q.counter_reload[c] == '0 && state_q.item_counter[c] == '0;
         assign interrupt_status[c][pdc_pkg::IRQ_TRANSFER_ERROR_FLAG_BIT] = state_q.err[c];
         assign busy[c] = state_q.st != pdc_pkg::ST_IDLE && 32'(state_q.ch) == c;
         // R12 serve while enabled, not halted and items remain
         assign elig[c] = state_q.en[c] && !state_q.err[c] && state_q.item_counter[c] != '0
                          && periph_req_i[state_q.peripheral_selector_code[c]];
         // R18 unmasked sources drive the line
         assign irq_o[c] = |(interrupt_status[c] & state_q.interrupt_mask[c]);
      end
   endgenerate

   // R15 lowest channel number first
   always_comb begin
      grant = '0;
      for (int c = NCH - 1; c >= 0; c--) begin
         if (elig[c]) begin
            grant = CHW'(c);
         end
      end
   end

   // R21 acknowledge as the item starts
   always_comb begin
      periph_ack_o = '0;
      if (state_q.st == pdc_pkg::ST_IDLE && elig != '0) begin
         periph_ack_o[state_q.peripheral_selector_code[grant]] = 1'b1;
      end
   end

   // R20 live pointer and counter on read
   always_comb begin
      rd_word = pdc_pkg::RST_WORD;
      if (bus_hit) begin
         unique case (bus_off)
            pdc_pkg::OFF_MEMORY_POINTER: rd_word = state_q.memory_pointer[bus_ch];
            pdc_pkg::OFF_PERIPHERAL_SELECT: rd_word = 32'(state_q.peripheral_selector_code[bus_ch]);
            pdc_pkg::OFF_ITEM_COUNTER: rd_word = 32'(state_q.item_counter[bus_ch]);
            pdc_pkg::OFF_POINTER_RELOAD: rd_word = state_q.pointer_reload[bus_ch];
            pdc_pkg::OFF_COUNTER_RELOAD: rd_word = 32'(state_q.counter_reload[bus_ch]);
            pdc_pkg::OFF_CHANNEL_MODE: rd_word = 32'(state_q.size[bus_ch]);
            pdc_pkg::OFF_CHANNEL_STATUS: rd_word = 32'(state_q.en[bus_ch]);
            pdc_pkg::OFF_INTERRUPT_MASK: rd_word = 32'(state_q.interrupt_mask[bus_ch]);
            pdc_pkg::OFF_INTERRUPT_STATUS: rd_word = 32'(interrupt_status[bus_ch]);
            default: rd_word = pdc_pkg::RST_WORD;
         endcase
      end
   end

   assign item_fin = (state_q.st == pdc_pkg::ST_MEM_WR && mem_done_i && !mem_err_i)
                     || (state_q.st == pdc_pkg::ST_PER_WR && pb_done_i);
   assign mem_fail = mem_req_o && mem_done_i && mem_err_i;

   // R10 memory side uses the item size and its lanes
   assign mem_req_o = state_q.st == pdc_pkg::ST_MEM_WR || state_q.st == pdc_pkg::ST_MEM_RD;
   assign mem_we_o = state_q.st == pdc_pkg::ST_MEM_WR;
   assign mem_addr_o = state_q.memory_pointer[state_q.ch];
   assign mem_size_o = state_q.size[state_q.ch];
   assign mem_wdata_o = lane_put(state_q.size[state_q.ch], state_q.data);
   // R01 holding register follows the selector code
   assign pb_req_o = state_q.st == pdc_pkg::ST_PER_RD || state_q.st == pdc_pkg::ST_PER_WR;
   assign pb_we_o = state_q.st == pdc_pkg::ST_PER_WR;
   assign pb_addr_o = hold_addr(state_q.peripheral_selector_code[state_q.ch]);
   assign pb_wdata_o = state_q.data;

   always_comb begin
      state_d = state_q;
      state_d.ack = 1'b0;
      if ((avs_read_i || avs_write_i) && !state_q.ack) begin
         state_d.ack = 1'b1;
         state_d.rdata = rd_word;
      end
      for (int c = 0; c < NCH; c++) begin
         // R06 reload whenever counter empty, reload counter loaded and channel not busy
         // R08 also covers a reload write landing on an empty counter
         if (state_q.item_counter[c] == '0 && state_q.counter_reload[c] != '0 && !busy[c]) begin
            state_d.memory_pointer[c] = state_q.pointer_reload[c];
            state_d.item_counter[c] = state_q.counter_reload[c];
            // R07 reload registers emptied
            state_d.pointer_reload[c] = pdc_pkg::RST_WORD;
            state_d.counter_reload[c] = '0;
         end
      end
      unique case (state_q.st)
         pdc_pkg::ST_IDLE: begin
            // R05 a freshly loaded counter is eligible next cycle
            if (elig != '0) begin
               state_d.ch = grant;
               state_d.st = pid_is_tx(state_q.peripheral_selector_code[grant]) ? pdc_pkg::ST_MEM_RD
                                                          : pdc_pkg::ST_PER_RD;
            end
         end
         pdc_pkg::ST_PER_RD: begin
            if (pb_done_i) begin
               // R09 bits above the item size read as zero
               state_d.data = mask_item(state_q.size[state_q.ch], pb_rdata_i);
               state_d.st = pdc_pkg::ST_MEM_WR;
            end
         end
         pdc_pkg::ST_MEM_RD: begin
            if (mem_done_i) begin
               state_d.data = lane_get(state_q.size[state_q.ch], state_q.memory_pointer[state_q.ch][1:0],
                                       mem_rdata_i);
               state_d.st = mem_err_i ? pdc_pkg::ST_IDLE : pdc_pkg::ST_PER_WR;
            end
         end
         pdc_pkg::ST_MEM_WR: begin
            if (mem_done_i) begin
               state_d.st = pdc_pkg::ST_IDLE;
            end
         end
         pdc_pkg::ST_PER_WR: begin
            if (pb_done_i) begin
               state_d.st = pdc_pkg::ST_IDLE;
            end
         end
         default: state_d.st = pdc_pkg::ST_IDLE;
      endcase
      if (item_fin) begin
         // R03 pointer advances by the item size
         state_d.memory_pointer[state_q.ch] = state_q.memory_pointer[state_q.ch] + step_of(state_q.size[state_q.ch]);
         // R04 one item done
         state_d.item_counter[state_q.ch] = state_q.item_counter[state_q.ch] - pdc_pkg::CNT_W'(1);
      end
      if (bus_wr) begin
         unique case (bus_off)
            pdc_pkg::OFF_MEMORY_POINTER: begin
               state_d.memory_pointer[bus_ch] = be_merge(state_q.memory_pointer[bus_ch], avs_writedata_i,
                                              avs_byteenable_i);
            end
            pdc_pkg::OFF_PERIPHERAL_SELECT: begin
               // R01 new selector takes effect at once, also on the holding address of an item in flight
               if (avs_byteenable_i[0]) begin
                  state_d.peripheral_selector_code[bus_ch] = avs_writedata_i[PID_W-1:0];
               end
            end
            pdc_pkg::OFF_ITEM_COUNTER: begin
               state_d.item_counter[bus_ch] = pdc_pkg::CNT_W'(be_merge(32'(state_q.item_counter[bus_ch]),
                                                 avs_writedata_i, avs_byteenable_i));
            end
            pdc_pkg::OFF_POINTER_RELOAD: begin
               state_d.pointer_reload[bus_ch] = be_merge(state_q.pointer_reload[bus_ch], avs_writedata_i,
                                               avs_byteenable_i);
            end
            pdc_pkg::OFF_COUNTER_RELOAD: begin
               state_d.counter_reload[bus_ch] = pdc_pkg::CNT_W'(be_merge(32'(state_q.counter_reload[bus_ch]),
                                                  avs_writedata_i, avs_byteenable_i));
            end
            pdc_pkg::OFF_CHANNEL_CONTROL: begin
               // R11 disable wins over enable in one write
               if (avs_writedata_i[pdc_pkg::CTRL_TEN_BIT]) begin
                  state_d.en[bus_ch] = 1'b1;
               end
               if (avs_writedata_i[pdc_pkg::CTRL_TRANSFER_DISABLE_BIT_BIT]) begin
                  state_d.en[bus_ch] = 1'b0;
               end
               if (avs_writedata_i[pdc_pkg::CTRL_ERROR_CLEAR_BIT_BIT]) begin
                  state_d.err[bus_ch] = 1'b0;
               end
            end
            pdc_pkg::OFF_CHANNEL_MODE: begin
               // R02 item size per channel
               if (avs_byteenable_i[0]) begin
                  state_d.size[bus_ch] = avs_writedata_i[1:0];
               end
            end
            pdc_pkg::OFF_INTERRUPT_ENABLE: begin
               // R13 set mask bits
               state_d.interrupt_mask[bus_ch] = state_q.interrupt_mask[bus_ch] | avs_writedata_i[pdc_pkg::IRQ_W-1:0];
            end
            pdc_pkg::OFF_INTERRUPT_DISABLE: begin
               // R13 clear mask bits
               state_d.interrupt_mask[bus_ch] = state_q.interrupt_mask[bus_ch] & ~avs_writedata_i[pdc_pkg::IRQ_W-1:0];
            end
            default: begin
            end
         endcase
      end
      // R16 error halts the failing channel only, set beats clear
      if (mem_fail) begin
         state_d.err[state_q.ch] = 1'b1;
         state_d.st = pdc_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   logic [31:0] act_mar;
   logic [pdc_pkg::CNT_W-1:0] act_tcr;
   logic [31:0] act_step;
   logic [NCH-1:0] below;
   logic [pdc_pkg::CNT_W-1:0] c0_tcr;
   logic [pdc_pkg::CNT_W-1:0] c0_counter_reload;
   logic [31:0] c0_pointer_reload;
   logic c0_ctrl_on;
   logic act_err;

   assign act_mar = state_q.memory_pointer[state_q.ch];
   assign act_tcr = state_q.item_counter[state_q.ch];
   assign act_step = step_of(state_q.size[state_q.ch]);
   assign act_err = state_q.err[state_q.ch];
   assign below = NCH'((NCH'(1) << grant) - NCH'(1));
   assign c0_tcr = state_q.item_counter[0];
   assign c0_counter_reload = state_q.counter_reload[0];
   assign c0_pointer_reload = state_q.pointer_reload[0];
   assign c0_ctrl_on = bus_wr && bus_ch == '0 && bus_off == pdc_pkg::OFF_CHANNEL_CONTROL
                       && avs_writedata_i[pdc_pkg::CTRL_TEN_BIT]
                       && !avs_writedata_i[pdc_pkg::CTRL_TRANSFER_DISABLE_BIT_BIT];

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!resetn_i);

   sequence mem_fail_s;
      mem_req_o && mem_done_i && mem_err_i;
   endsequence

   sequence halted_s;
      act_err && state_q.st == pdc_pkg::ST_IDLE;
   endsequence

   bus_answer_a: assert property ((avs_read_i || avs_write_i) |-> ##[0:1] !avs_waitrequest_o)
      else $error("bus request not answered within one cycle");
   grant_prio_a: assert property (state_q.st == pdc_pkg::ST_IDLE && elig != '0 |-> // R15
      elig[grant] && (elig & below) == '0 ##1 state_q.ch == $past(grant))
      else $error("granted channel is not the lowest requester");
   ptr_step_a: assert property (item_fin && !bus_wr |=> // R03
      act_mar == $past(act_mar) + $past(act_step))
      else $error("pointer did not advance by item size");
   cnt_dec_a: assert property (item_fin && !bus_wr |=> act_tcr == $past(act_tcr) - 16'h0001) // R04
      else $error("item counter did not drop by one");
   reload_clear_a: assert property (c0_tcr == '0 && c0_counter_reload != '0 && !busy[0] && !bus_wr |=> // R07
      c0_counter_reload == '0 && c0_pointer_reload == '0 && c0_tcr == $past(c0_counter_reload))
      else $error("reload did not copy and clear");
   err_halt_a: assert property (mem_fail_s |=> halted_s ##1 !pb_req_o || !act_err) // R16
      else $error("channel not halted after memory error");
   enable_status_a: assert property (c0_ctrl_on |=> state_q.en[0]) // R11
      else $error("enable bit not reflected in status");
   irq_transfer_error_flag_a: assert property (mem_fail_s ##0 state_q.interrupt_mask[state_q.ch][pdc_pkg::IRQ_TRANSFER_ERROR_FLAG_BIT] // R18
      |=> irq_o[state_q.ch])
      else $error("transfer error did not raise interrupt");
   item_mask_a: assert property (state_q.st == pdc_pkg::ST_MEM_WR // R09
      && state_q.size[state_q.ch] == pdc_pkg::SIZE_BYTE |-> state_q.data[31:8] == '0)
      else $error("byte item carries upper bits");
   no_err_ack_a: assert property (periph_ack_o != '0 |-> !state_q.err[grant] && state_q.en[grant]) // R16
      else $error("halted channel acknowledged a request");

endmodule

// [tb/pdc_far_model.sv]
/* far side of the dma engine: one memory and the peripheral holding registers.
   assumes the engine holds each request until the matching done pulse. */
`timescale 1ns/1ps
module pdc_far_model #(
   parameter logic [31:0] MKEY = 32'h5A5A_3C3C
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic [3:0] dly_i,
   input wire logic [31:0] pdata_i,
   input wire logic mem_req_i,
   input wire logic [31:0] mem_addr_i,
   input wire logic pb_req_i,
   output logic [31:0] mem_rdata_o,
   output logic mem_done_o,
   output logic mem_err_o,
   output logic [31:0] pb_rdata_o,
   output logic pb_done_o
);
   logic [3:0] mcnt_q, pcnt_q;
   always_ff @(posedge clk_sys_i) begin
      mcnt_q <= (mem_req_i && !mem_done_o) ? mcnt_q + 4'h1 : 4'h0;
      pcnt_q <= (pb_req_i && !pb_done_o) ? pcnt_q + 4'h1 : 4'h0;
      mem_done_o <= resetn_i && mem_req_i && !mem_done_o && mcnt_q == dly_i;
      pb_done_o <= resetn_i && pb_req_i && !pb_done_o && pcnt_q == dly_i;
   end
   // top sixteenth of the space is not backed by memory
   assign mem_err_o = mem_done_o && mem_addr_i[31:28] == 4'hF;
   // data lines show the inverse outside a done cycle
   assign mem_rdata_o = mem_done_o ? mem_addr_i ^ MKEY : ~(mem_addr_i ^ MKEY);
   assign pb_rdata_o = pb_done_o ? pdata_i : ~pdata_i;
endmodule

// [tb/test_peripheral_dma_channels.sv]
/* bench for the dma engine: registers, sizes, reload, priority, error, output side.
   assumes the far-side model answers memory and holding register accesses. */
`timescale 1ns/1ps
module test_peripheral_dma_channels;
   localparam logic [31:0] MKEY = 32'h5A5A_3C3C;
   logic clk_sys_i = 1'b0, resetn_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
   logic [6:0] avs_address_i = 7'h00;
   logic [31:0] avs_writedata_i = 32'h0, pdata = 32'h0, d, avs_readdata_o, pb_addr_o, pb_wdata_o;
   logic [31:0] pb_rdata_i, mem_addr_o, mem_wdata_o, mem_rdata_i;
   logic [3:0] periph_req_i = 4'h0, dly = 4'h0, periph_ack_o;
   logic [1:0] irq_o, mem_size_o;
   logic avs_waitrequest_o, pb_req_o, pb_we_o, pb_done_i, mem_req_o, mem_we_o;
   logic mem_done_i, mem_err_i;
   int fails = 0, tests_run = 0, cycles = 0, seed = 32'h79E5F518;
   logic [65:0] exp_mw[$];
   logic [63:0] exp_pw[$];
   logic [31:0] exp_rd[$];
   always #10 clk_sys_i = ~clk_sys_i;
   pdc_dma_top #(.NCH(2), .PID_W(2)) dut (.clk_sys_i, .resetn_i, .avs_address_i, .avs_read_i,
      .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hF), .avs_readdata_o,
      .avs_waitrequest_o, .periph_req_i, .periph_ack_o, .pb_req_o, .pb_we_o, .pb_addr_o,
      .pb_wdata_o, .pb_rdata_i, .pb_done_i, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_size_o,
      .mem_wdata_o, .mem_rdata_i, .mem_done_i, .mem_err_i, .irq_o);
   pdc_far_model #(.MKEY(MKEY)) far (.clk_sys_i, .resetn_i, .dly_i(dly), .pdata_i(pdata),
      .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o), .pb_req_i(pb_req_o),
      .mem_rdata_o(mem_rdata_i), .mem_done_o(mem_done_i), .mem_err_o(mem_err_i),
      .pb_rdata_o(pb_rdata_i), .pb_done_o(pb_done_i));
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   function automatic logic [6:0] ra(input int c, input logic [5:0] o);
      return {c[0], o};
   endfunction
   function automatic logic [31:0] lanes(input logic [1:0] s, input logic [31:0] v);
      return (s == 2'h0) ? {4{v[7:0]}} : (s == 2'h1) ? {2{v[15:0]}} : v;
   endfunction
   task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] v);
      avs_address_i <= a;
      avs_writedata_i <= v;
      avs_write_i <= w;
      avs_read_i <= !w;
      do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task automatic wr(input logic [6:0] a, input logic [31:0] v);
      bus(1'b1, a, v);
   endtask
   task automatic rd(input logic [6:0] a, input logic [31:0] v);
      exp_rd.push_back(v);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic drain;
      while (exp_mw.size() + exp_pw.size() > 0) @(posedge clk_sys_i);
      repeat (3) @(posedge clk_sys_i);
      periph_req_i <= 4'h0;
      @(posedge clk_sys_i);
   endtask
   always @(negedge clk_sys_i) begin
      if (avs_read_i && !avs_waitrequest_o) begin
         tests_run++;
         if (exp_rd.size() == 0 || avs_readdata_o !== exp_rd[0]) begin
            fails++;
            $display("MISMATCH %0t register read %h", $time, avs_readdata_o);
         end
         if (exp_rd.size() > 0) void'(exp_rd.pop_front());
      end
      if (mem_req_o && mem_we_o && mem_done_i && !mem_err_i) begin
         tests_run++;
         if (exp_mw.size() == 0 || {mem_size_o, mem_addr_o, mem_wdata_o} !== exp_mw[0]) begin
            fails++;
            $display("MISMATCH %0t memory write %h %h", $time, mem_addr_o, mem_wdata_o);
         end
         if (exp_mw.size() > 0) void'(exp_mw.pop_front());
      end
      if (pb_req_o && pb_we_o && pb_done_i) begin
         tests_run++;
         if (exp_pw.size() == 0 || {pb_addr_o, pb_wdata_o} !== exp_pw[0]) begin
            fails++;
            $display("MISMATCH %0t holding write %h %h", $time, pb_addr_o, pb_wdata_o);
         end
         if (exp_pw.size() > 0) void'(exp_pw.pop_front());
      end
   end
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         $display("MISMATCH %0t run did not complete", $time);
         tally_and_finish();
      end
   end
   initial begin
      repeat (5) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      @(posedge clk_sys_i);
      for (int o = 0; o < 13; o++) rd(ra(1, o * 4), (o == 11) ? 32'h3 : 32'h0);
      for (int s = 0; s < 3; s++) begin
         d = $random(seed);
         pdata <= d;
         dly <= 4'(s * 3);
         wr(ra(1, 6'h18), s);
         wr(ra(1, 6'h04), 32'h1);
         wr(ra(1, 6'h00), 32'h100);
         wr(ra(1, 6'h14), 32'h1);
         for (int i = 0; i < 2; i++)
            exp_mw.push_back({2'(s), 32'h100 + i * (1 << s), lanes(s, d)});
         periph_req_i <= 4'h2;
         wr(ra(1, 6'h08), 32'h2);
         drain();
         rd(ra(1, 6'h00), 32'h100 + 2 * (1 << s));
         rd(ra(1, 6'h08), 32'h0);
      end
      wr(ra(0, 6'h18), 32'h2);
      wr(ra(0, 6'h0C), 32'h200);
      wr(ra(0, 6'h10), 32'h2);
      rd(ra(0, 6'h00), 32'h200);
      rd(ra(0, 6'h08), 32'h2);
      wr(ra(0, 6'h0C), 32'h300);
      wr(ra(0, 6'h10), 32'h1);
      wr(ra(0, 6'h14), 32'h1);
      rd(ra(0, 6'h1C), 32'h1);
      for (int i = 0; i < 3; i++)
         exp_mw.push_back({2'h2, 32'h200 + ((i == 2) ? 32'h100 : i * 4), d});
      periph_req_i <= 4'h1;
      drain();
      rd(ra(0, 6'h0C), 32'h0);
      rd(ra(0, 6'h10), 32'h0);
      wr(ra(0, 6'h08), 32'h1);
      wr(ra(1, 6'h00), 32'h400);
      wr(ra(1, 6'h08), 32'h1);
      exp_mw.push_back({2'h2, 32'h304, d});
      exp_mw.push_back({2'h2, 32'h400, d});
      periph_req_i <= 4'h3;
      drain();
      wr(ra(1, 6'h00), 32'hF000_0000);
      wr(ra(1, 6'h20), 32'h4);
      periph_req_i <= 4'h2;
      wr(ra(1, 6'h08), 32'h2);
      for (int i = 0; i < 50 && irq_o[1] !== 1'b1; i++) @(posedge clk_sys_i);
      tests_run++;
      if (irq_o[1] !== 1'b1) begin
         fails++;
         $display("MISMATCH %0t no error interrupt", $time);
      end
      rd(ra(1, 6'h08), 32'h2);
      rd(ra(1, 6'h2C), 32'h5);
      rd(ra(1, 6'h28), 32'h4);
      wr(ra(1, 6'h00), 32'h500);
      for (int i = 0; i < 2; i++) exp_mw.push_back({2'h2, 32'h500 + i * 4, d});
      wr(ra(1, 6'h14), 32'h100);
      drain();
      wr(ra(1, 6'h24), 32'h4);
      rd(ra(1, 6'h28), 32'h0);
      wr(ra(1, 6'h14), 32'h2);
      rd(ra(1, 6'h1C), 32'h0);
      periph_req_i <= 4'h2;
      wr(ra(1, 6'h08), 32'h1);
      repeat (10) @(posedge clk_sys_i);
      rd(ra(1, 6'h08), 32'h1);
      periph_req_i <= 4'h0;
      wr(ra(0, 6'h18), 32'h1);
      wr(ra(0, 6'h04), 32'h2);
      wr(ra(0, 6'h00), 32'h602);
      exp_pw.push_back({32'h8, ((32'h602 ^ MKEY) >> 16) & 32'h0000_FFFF});
      periph_req_i <= 4'h4;
      wr(ra(0, 6'h08), 32'h1);
      drain();
      rd(ra(0, 6'h00), 32'h604);
      tally_and_finish();
   end
endmodule
